// file: include/tcc_pkg.sv
// shared types and constants of the two channel capture/compare timer
package tcc_pkg;

    // ==========================================================
    // widths and counts
    localparam int TCC_CW = 16;              // counter width
    localparam int TCC_NCH = 2;              // channel count
    localparam int TCC_DIVW = 6;             // prescaler divider width

    // ==========================================================
    // reset values
    localparam logic [15:0] TCC_WRAP_RST = 16'hffff; // free-running wrap
    localparam logic [15:0] TCC_CNT_RST = 16'h0000;  // counter after reset
    localparam logic [5:0] TCC_DIV_RST = 6'h00;      // divider after reset

    // ==========================================================
    // prescaler select code for the external clock pin
    localparam logic [2:0] TCC_PS_EXT = 3'h7;

    // ==========================================================
    // edge/level select codes (hi, lo)
    localparam logic [1:0] TCC_ELS_OFF = 2'h0;  // pin not used
    localparam logic [1:0] TCC_ELS_TGL = 2'h1;  // compare: toggle / cap rise
    localparam logic [1:0] TCC_ELS_CLR = 2'h2;  // compare: clear / cap fall
    localparam logic [1:0] TCC_ELS_SET = 2'h3;  // compare: set / cap both

    // ==========================================================
    // per channel configuration, one control register's worth
    typedef struct packed {
        logic irq_en;                // channel interrupt enable
        logic cmp_mode;              // 1 output compare, 0 input capture
        logic edge_level_select_hi;  // edge/level select, high bit
        logic edge_level_select_lo;  // edge/level select, low bit
        logic toggle_on_overflow_bit; // toggle pin at wrap
        logic max_duty_bit;          // force 100 percent duty while toggle_on_overflow_bit is clear
    } tcc_ch_cfg_t;

    // software flag access strobes for one flag
    typedef struct packed {
        logic rd;    // control register read
        logic wr;    // control register write
        logic val;   // value written to the flag bit
    } tcc_flag_acc_t;

endpackage : tcc_pkg

// file: logic/tcc_prescaler.sv
// counter clock prescaler: seven bus clock rates or external pin
`timescale 1ns/1ps
module tcc_prescaler
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] prescaler_select,
    input wire logic external_timer_clock_pin,
    input wire logic hold,
    input wire logic clear,
    output logic tick
);

    // ==========================================================
    // state
    logic [TCC_DIVW-1:0] div_q, div_d;   // bus clock divider
    logic ext_s1_q, ext_s2_q, ext_p_q;   // pin synchroniser + history
    logic tick_q, tick_d;                // counter enable pulse
    logic [TCC_DIVW-1:0] mask;           // divider terminal mask

    // next state
    always_comb begin
        mask = TCC_DIVW'((7'h01 << prescaler_select) - 7'h01);
        div_d = div_q;
        tick_d = 1'b0;
        if (clear) begin
            // counter reset also restarts the divider
            div_d = TCC_DIV_RST;
        end else if (!hold) begin
            div_d = div_q + 6'h01;
            if (prescaler_select == TCC_PS_EXT) begin
                // rising edge of the synchronised pin
                tick_d = ext_s2_q & ~ext_p_q;
            end else begin
                // terminal count of the selected power of two
                tick_d = (div_q & mask) == mask;
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_q <= TCC_DIV_RST;
            tick_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_p_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
            ext_s1_q <= external_timer_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_p_q <= ext_s2_q;
        end
    end

    assign tick = tick_q;

endmodule : tcc_prescaler

// file: logic/tcc_edge_detect.sv
// capture pin synchroniser and programmable edge detector
`timescale 1ns/1ps
module tcc_edge_detect
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    input wire logic enable,
    input wire logic [1:0] edge_sel,
    output logic hit
);

    // ==========================================================
    // synchroniser, history and event
    logic s1_q, s2_q, p_q;   // two stage sync, then history
    logic hit_q, hit_d;      // qualified edge pulse

    // edge qualification, lo bit rising, hi bit falling
    always_comb begin
        hit_d = enable & ((edge_sel[0] & s2_q & ~p_q)
                        | (edge_sel[1] & ~s2_q & p_q));
    end

    // registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            p_q <= 1'b0;
            hit_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            p_q <= s2_q;
            hit_q <= hit_d;
        end
    end

    assign hit = hit_q;

endmodule : tcc_edge_detect

// file: logic/tcc_timer.sv
// two channel capture/compare timer core
//
// Functional notes
// [RQ1] 16-bit up-counter, free or modulo wrap
// [RQ2] counter readable anytime without disturbing count
// [RQ3] each channel independently capture or compare
// [RQ4] three-bit select: seven rates or pin
// [RQ5] capture edge latches counter into channel
// [RQ6] per channel edge select bits pick polarity
// [RQ7] triggers: rising, falling or either edge
// [RQ8] captured value is prior count plus one
// [RQ9] every edge overwrites capture, flag regardless
// [RQ10] events set flag; enabled flag requests interrupt
// [RQ11] reset leaves channel values untouched
// [RQ12] compare match sets, clears or toggles pin
// [RQ13] unbuffered write replaces compare value immediately
// [RQ14] software times smaller/larger unbuffered updates
// [RQ15] link bit pairs channels, channel 0 first
// [RQ16] overflow hands control to last written pair
// [RQ17] linked: channel 0 controls, channel 1 free
// [RQ18] software avoids writing the active pair
// [RQ19] toggle-on-overflow flips pin at wrap
// [RQ20] software picks compare action per pulse level
// [RQ21] counts zero through wrap value inclusive
// [RQ22] duty equals compare value over period
// [RQ23] wrap to zero sets overflow flag, interrupt
// [RQ24] max duty without toggle gives constant high
// [RQ25] flag cleared by read then write zero
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] prescaler_select,
    input wire logic external_timer_clock_pin,
    input wire logic counter_stop,
    input wire logic counter_reset,
    input wire logic [7:0] counter_wrap_high,
    input wire logic [7:0] counter_wrap_low,
    input wire logic ovf_irq_en,
    input wire tcc_flag_acc_t ovf_acc,
    input wire logic link_mode_bit,
    input wire tcc_ch_cfg_t [TCC_NCH-1:0] ch_cfg,
    input wire tcc_flag_acc_t [TCC_NCH-1:0] ch_acc,
    input wire logic [TCC_NCH-1:0] val_wr_hi,
    input wire logic [TCC_NCH-1:0] val_wr_lo,
    input wire logic [7:0] val_wr_data,
    input wire logic [TCC_NCH-1:0] ch_pin_in,
    output logic [TCC_CW-1:0] counter_value,
    output logic counter_overflow_flag,
    output logic ovf_irq,
    output logic [TCC_NCH-1:0] ch_event_flag,
    output logic [TCC_NCH-1:0] ch_irq,
    output logic [TCC_CW-1:0] ch_value_0,
    output logic [TCC_CW-1:0] ch_value_1,
    output logic [TCC_NCH-1:0] ch_pin_out,
    output logic [TCC_NCH-1:0] ch_pin_oe,
    output logic active_pair
);

    // ==========================================================
    // helpers
    // compare action on a pin for an edge/level code
    function automatic logic cmp_action(input logic [1:0] els,
                                        input logic cur);
        case (els)
            TCC_ELS_TGL: cmp_action = ~cur;
            TCC_ELS_CLR: cmp_action = 1'b0;
            TCC_ELS_SET: cmp_action = 1'b1;
            default: cmp_action = cur;
        endcase
    endfunction : cmp_action

    // ==========================================================
    // declarations
    logic tick;                              // counter enable
    logic [TCC_CW-1:0] wrap;                 // modulo value
    logic [TCC_CW-1:0] cnt_q, cnt_d;         // counter
    logic [TCC_CW-1:0] cnt_h1_q, cnt_h2_q;   // counter history, capture
    logic ovf_ev;                            // wrap this cycle
    logic [TCC_NCH-1:0] cap_ev;              // capture events
    logic [TCC_NCH-1:0] cmp_ev;              // compare matches
    logic [TCC_NCH-1:0] cmp_en;              // channel in compare use
    logic [TCC_NCH-1:0] cap_en;              // channel in capture use
    logic [1:0] els [TCC_NCH];               // edge/level per channel
    logic [TCC_CW-1:0] val_q [TCC_NCH];      // channel values, no reset
    logic [TCC_CW-1:0] cmp_val [TCC_NCH];    // value each compare uses
    logic act_q, act_d;                      // pair in control (linked)
    logic last_q, last_d;                    // pair written last
    logic [TCC_NCH:0] flag_q, flag_d;        // ovf flag on top bit
    logic [TCC_NCH:0] arm_q, arm_d;          // flag read while set
    logic [TCC_NCH:0] irq_q, irq_d;          // registered requests
    logic [TCC_NCH:0] irq_en;                // enables, ovf on top
    tcc_flag_acc_t acc [TCC_NCH+1];          // flag accesses
    logic [TCC_NCH-1:0] pin_q, pin_d;        // compare pin levels
    logic [TCC_NCH-1:0] oe_q, oe_d;          // pin drive enables

    assign wrap = {counter_wrap_high, counter_wrap_low};

    // ==========================================================
    // prescaler
    // [RQ4] clock source select
    tcc_prescaler u_psc (
        .clk(clk),
        .nrst(nrst),
        .prescaler_select(prescaler_select),
        .external_timer_clock_pin(external_timer_clock_pin),
        .hold(counter_stop),
        .clear(counter_reset),
        .tick(tick)
    );

    // ==========================================================
    // channel mode decode and capture detectors
    genvar gi;
    generate
        for (gi = 0; gi < TCC_NCH; gi++) begin : g_ch
            assign els[gi] = {ch_cfg[gi].edge_level_select_hi,
                              ch_cfg[gi].edge_level_select_lo};
            // [RQ3] [RQ17] independent modes, channel 1 idle when linked
            if (gi == 0) begin : g_c0
                assign cmp_en[gi] = ch_cfg[gi].cmp_mode | link_mode_bit;
            end else begin : g_c1
                assign cmp_en[gi] = ch_cfg[gi].cmp_mode & ~link_mode_bit;
            end
            assign cap_en[gi] = ~ch_cfg[gi].cmp_mode &
                                ~(link_mode_bit);
            // [RQ6] [RQ7] edge select per channel
            tcc_edge_detect u_edge (
                .clk(clk),
                .nrst(nrst),
                .pin(ch_pin_in[gi]),
                .enable(cap_en[gi]),
                .edge_sel(els[gi]),
                .hit(cap_ev[gi])
            );
            assign acc[gi] = ch_acc[gi];
            assign irq_en[gi] = ch_cfg[gi].irq_en;
        end
    endgenerate
    assign acc[TCC_NCH] = ovf_acc;
    assign irq_en[TCC_NCH] = ovf_irq_en;

    // [RQ15] [RQ16] linked pair picks the value in control
    assign cmp_val[0] = (link_mode_bit && act_q) ? val_q[1] : val_q[0];
    assign cmp_val[1] = val_q[1];

    // ==========================================================
    // counter
    // [RQ1] [RQ21] count zero through wrap value inclusive
    always_comb begin
        cnt_d = cnt_q;
        ovf_ev = 1'b0;
        if (counter_reset) begin
            cnt_d = TCC_CNT_RST;
        end else if (tick) begin
            if (cnt_q == wrap) begin
                cnt_d = TCC_CNT_RST;
                ovf_ev = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // [RQ2] counter output is a plain copy, reads have no side effect
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= TCC_CNT_RST;
            cnt_h1_q <= TCC_CNT_RST;
            cnt_h2_q <= TCC_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
            // history undoes the pin sync latency
            cnt_h1_q <= cnt_q;
            cnt_h2_q <= cnt_h1_q;
        end
    end

    // [RQ12] [RQ13] match as the count reaches the live value
    always_comb begin
        for (int i = 0; i < TCC_NCH; i++) begin
            cmp_ev[i] = cmp_en[i] & tick & ~counter_reset &
                        (cnt_d == cmp_val[i]);
        end
    end

    // ==========================================================
    // channel values, deliberately without reset
    // [RQ11] contents survive reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < TCC_NCH; i++) begin
            if (cap_ev[i]) begin
                // [RQ5] [RQ8] [RQ9] capture overwrites unread value
                val_q[i] <= cnt_h2_q;
            end else begin
                // [RQ13] byte writes take effect at once
                if (val_wr_hi[i]) begin
                    val_q[i][15:8] <= val_wr_data;
                end
                if (val_wr_lo[i]) begin
                    val_q[i][7:0] <= val_wr_data;
                end
            end
        end
    end

    // ==========================================================
    // linked pair selection
    always_comb begin
        last_d = last_q;
        act_d = act_q;
        if (!link_mode_bit) begin
            // [RQ15] unlinked: channel 0 pair leads on linking
            last_d = 1'b0;
            act_d = 1'b0;
        end else begin
            // most recent write wins
            if (val_wr_hi[1] | val_wr_lo[1]) begin
                last_d = 1'b1;
            end else if (val_wr_hi[0] | val_wr_lo[0]) begin
                last_d = 1'b0;
            end
            // [RQ16] hand over control only at overflow
            if (ovf_ev) begin
                act_d = last_d;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            last_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            last_q <= last_d;
            act_q <= act_d;
        end
    end

    // ==========================================================
    // event flags and requests
    always_comb begin
        for (int i = 0; i <= TCC_NCH; i++) begin
            flag_d[i] = flag_q[i];
            arm_d[i] = arm_q[i];
            // [RQ25] read while set arms the clear
            if (acc[i].rd && flag_q[i]) begin
                arm_d[i] = 1'b1;
            end
            // [RQ25] write of zero after arming clears, one is ignored
            if (acc[i].wr) begin
                if (arm_q[i] && !acc[i].val) begin
                    flag_d[i] = 1'b0;
                end
                arm_d[i] = 1'b0;
            end
        end
        // [RQ10] events set flags, set wins over clear
        for (int i = 0; i < TCC_NCH; i++) begin
            if (cap_ev[i] | cmp_ev[i]) begin
                flag_d[i] = 1'b1;
            end
        end
        // [RQ23] overflow flag
        if (ovf_ev) begin
            flag_d[TCC_NCH] = 1'b1;
        end
        // [RQ10] [RQ23] enabled flags request an interrupt
        irq_d = flag_d & irq_en;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= '0;
            arm_q <= '0;
            irq_q <= '0;
        end else begin
            flag_q <= flag_d;
            arm_q <= arm_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // compare pins
    always_comb begin
        for (int i = 0; i < TCC_NCH; i++) begin
            pin_d[i] = pin_q[i];
            // drive only when compare uses the pin
            oe_d[i] = cmp_en[i] & (els[i] != TCC_ELS_OFF);
            if (oe_d[i]) begin
                // [RQ19] wrap toggle gives the period edge
                if (ovf_ev && ch_cfg[i].toggle_on_overflow_bit) begin
                    pin_d[i] = ~pin_d[i];
                end
                // [RQ12] [RQ22] compare action marks pulse end
                if (cmp_ev[i]) begin
                    pin_d[i] = cmp_action(els[i], pin_d[i]);
                end
                // [RQ24] max duty overrides while toggle is off
                if (ch_cfg[i].max_duty_bit &&
                    !ch_cfg[i].toggle_on_overflow_bit) begin
                    pin_d[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_q <= '0;
            oe_q <= '0;
        end else begin
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    // ==========================================================
    // outputs
    assign counter_value = cnt_q;
    assign counter_overflow_flag = flag_q[TCC_NCH];
    assign ovf_irq = irq_q[TCC_NCH];
    assign ch_event_flag = flag_q[TCC_NCH-1:0];
    assign ch_irq = irq_q[TCC_NCH-1:0];
    assign ch_value_0 = val_q[0];
    assign ch_value_1 = val_q[1];
    assign ch_pin_out = pin_q;
    assign ch_pin_oe = oe_q;
    assign active_pair = act_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_wrap_hit;
        tick && !counter_reset && cnt_q == wrap;
    endsequence

    a_cnt_wrap: assert property (s_wrap_hit |=> cnt_q == 16'h0000 // [RQ21]
        && counter_overflow_flag)
        else $error("counter did not wrap with overflow flag");
    a_cnt_step: assert property (tick && !counter_reset // [RQ1]
        && cnt_q != wrap |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step by one");
    a_cnt_hold: assert property (!tick && !counter_reset // [RQ2]
        |=> $stable(cnt_q))
        else $error("counter moved without a tick");
    a_cap_latch: assert property (cap_ev[0] // [RQ5]
        |=> ch_value_0 == $past(cnt_q, 3) && ch_event_flag[0])
        else $error("capture did not latch counter and flag");
    a_flag_keep: assert property (ch_event_flag[0] && ch_acc[0].wr // [RQ25]
        && ch_acc[0].val |=> ch_event_flag[0])
        else $error("write of one cleared the channel flag");
    a_irq_follow: assert property (##1 ch_irq[0] == // [RQ10]
        (ch_event_flag[0] && $past(ch_cfg[0].irq_en)))
        else $error("channel request does not follow flag");
    a_max_duty: assert property (ch_cfg[0].cmp_mode // [RQ24]
        && ch_cfg[0].max_duty_bit && !ch_cfg[0].toggle_on_overflow_bit
        && els[0] != TCC_ELS_OFF |=> ch_pin_out[0])
        else $error("max duty did not hold pin high");
    a_link_swap: assert property (link_mode_bit && ovf_ev // [RQ16]
        |=> active_pair == $past(last_d))
        else $error("linked pair not handed over at overflow");
    a_link_free: assert property (link_mode_bit // [RQ17]
        |=> !ch_pin_oe[1])
        else $error("channel 1 pin driven while linked");
    a_tov_flip: assert property (ovf_ev && cmp_en[0] && oe_q[0] // [RQ19]
        && !cmp_ev[0] && ch_cfg[0].toggle_on_overflow_bit
        && $stable(els[0]) |=> ch_pin_out[0] != $past(ch_pin_out[0]))
        else $error("pin did not toggle at overflow");

endmodule : tcc_timer

// file: tb/tcc_pin_model.sv
// far side model: drives the two capture pins with a chosen lag
`timescale 1ns/1ps
module tcc_pin_model (
    input wire logic clk,
    input wire logic [1:0] want,
    input wire logic [3:0] lag,
    output logic [1:0] pin
);
    int wait_q = 0; // cycles left before the pins follow
    initial pin = 2'h0;
    // pins follow the wanted level late, so prompt and slow edges both occur
    always @(negedge clk) begin
        if (pin == want) begin
            wait_q <= lag;
        end else if (wait_q == 0) begin
            pin <= want;
        end else begin
            wait_q <= wait_q - 1;
        end
    end
endmodule : tcc_pin_model

// file: tb/two_channel_capture_compare_timer_test.sv
// self-checking bench of the two channel capture/compare timer
`timescale 1ns/1ps
module two_channel_capture_compare_timer_test;
    import tcc_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'h0, nrst = 1'h0, external_timer_clock_pin = 1'h0;
    logic counter_stop = 1'h0, counter_reset = 1'h0, ovf_irq_en = 1'h1;
    logic link_mode_bit = 1'h0, active_pair, counter_overflow_flag, ovf_irq;
    logic [2:0] prescaler_select = 3'h0;
    logic [7:0] counter_wrap_high = 8'hff, counter_wrap_low = 8'hff;
    logic [7:0] val_wr_data = 8'h00;
    tcc_flag_acc_t ovf_acc = '0;
    tcc_ch_cfg_t [1:0] ch_cfg = '0;
    tcc_flag_acc_t [1:0] ch_acc = '0;
    logic [1:0] val_wr_hi = 2'h0, val_wr_lo = 2'h0, want = 2'h0, ch_pin_in;
    logic [1:0] ch_event_flag, ch_irq, ch_pin_out, ch_pin_oe;
    logic [3:0] lag = 4'h0;
    logic [15:0] counter_value, ch_value_0, ch_value_1, prev, old, got, d;
    int mismatches = 0, samples_checked = 0, cycles = 0, w, h;

    always #2.5 clk = ~clk; // 200 MHz bus clock

    tcc_timer i_dut (.clk, .nrst, .prescaler_select, .external_timer_clock_pin,
        .counter_stop, .counter_reset, .counter_wrap_high, .counter_wrap_low,
        .ovf_irq_en, .ovf_acc, .link_mode_bit, .ch_cfg, .ch_acc, .val_wr_hi,
        .val_wr_lo, .val_wr_data, .ch_pin_in, .counter_value,
        .counter_overflow_flag, .ovf_irq, .ch_event_flag, .ch_irq, .ch_value_0,
        .ch_value_1, .ch_pin_out, .ch_pin_oe, .active_pair);
    tcc_pin_model i_pins (.clk, .want, .lag, .pin(ch_pin_in));

    // ==========================================================
    // helpers
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e, string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    // byte writes: high then low
    task automatic wr_val(input int ch, input logic [15:0] v);
        @(negedge clk);
        val_wr_hi[ch] = 1'h1;
        val_wr_data = v[15:8];
        @(negedge clk);
        val_wr_hi[ch] = 1'h0;
        val_wr_lo[ch] = 1'h1;
        val_wr_data = v[7:0];
        @(negedge clk);
        val_wr_lo[ch] = 1'h0;
    endtask : wr_val
    // flag strobes, channel 2 meaning the overflow flag
    task automatic put(input int ch, input logic [2:0] a);
        @(negedge clk);
        if (ch == 2) begin
            ovf_acc = tcc_flag_acc_t'(a);
        end else begin
            ch_acc[ch] = tcc_flag_acc_t'(a);
        end
    endtask : put
    task automatic clr(input int ch, input logic v);
        put(ch, 3'h4); // read arms the clear
        put(ch, {2'h1, v}); // write the flag bit
        put(ch, 3'h0);
    endtask : clr
    task automatic restart;
        counter_reset = 1'h1;
        wait_n(1);
        counter_reset = 1'h0;
    endtask : restart
    task automatic high_count(input int n);
        h = 0;
        repeat (n) begin
            @(negedge clk);
            h += ch_pin_out[0];
        end
    endtask : high_count

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(65033));
        wait_n(5);
        nrst = 1'h1;
        {counter_wrap_high, counter_wrap_low} = 16'h0002;
        restart();
        wait_n(1); // first tick after a restart comes one cycle late
        prev = counter_value;
        repeat (8) begin
            wait_n(1);
            d = (prev == 16'h2) ? 16'h0 : prev + 16'h1;
            chk(counter_value, d, "wrap");
            prev = counter_value;
        end
        chk(counter_overflow_flag, 16'h1, "ovf flag");
        chk(ovf_irq, 16'h1, "ovf irq");
        {counter_wrap_high, counter_wrap_low} = 16'hffff;
        restart();
        clr(2, 1'h1);
        chk(counter_overflow_flag, 16'h1, "flag cleared by one");
        clr(2, 1'h0);
        chk({ovf_irq, counter_overflow_flag}, 16'h0, "flag kept");
        counter_stop = 1'h1;
        wait_n(2); // a tick already in flight may still land
        prev = counter_value;
        wait_n(20);
        chk(counter_value, prev, "stop holds");
        counter_stop = 1'h0;
        $display("counter test done");
        for (int n = 0; n < 7; n++) begin
            prescaler_select = 3'(n);
            wait_n(130);
            prev = counter_value;
            wait_n(128);
            chk(counter_value - prev, 16'(128 >> n), "rate");
        end
        prescaler_select = TCC_PS_EXT;
        wait_n(8);
        prev = counter_value;
        repeat (5) begin
            external_timer_clock_pin = 1'h1;
            wait_n(4);
            external_timer_clock_pin = 1'h0;
            wait_n(4);
        end
        wait_n(6);
        chk(counter_value - prev, 16'h5, "pin clock");
        prescaler_select = 3'h0;
        $display("prescaler test done");
        got = 16'($urandom);
        wr_val(0, got);
        chk(ch_value_0, got, "value write");
        nrst = 1'h0;
        wait_n(3);
        nrst = 1'h1;
        chk(ch_value_0, got, "value over reset");
        chk(counter_value, 16'h0, "counter reset");
        $display("reset test done");
        for (int ch = 0; ch < 2; ch++) begin
            wr_val(ch, 16'($urandom));
            for (int e = 1; e < 4; e++) begin
                ch_cfg[ch] = tcc_ch_cfg_t'(6'(32 + (e << 2)));
                lag = 4'($urandom_range(3));
                clr(ch, 1'h0);
                for (int lvl = 1; lvl >= 0; lvl--) begin
                    old = ch ? ch_value_1 : ch_value_0;
                    prev = counter_value;
                    want[ch] <= lvl[0]; // model sees it next clock
                    wait_n(lag + 8);
                    got = ch ? ch_value_1 : ch_value_0;
                    d = got - prev;
                    if (lvl ? e[0] : e[1]) begin
                        // pin moves lag+1 ticks on, stamp is one more
                        chk(d, 16'(lag + 2), "stamp");
                    end else begin
                        chk(got, old, "wrong edge");
                    end
                end
                chk({ch_irq[ch], ch_event_flag[ch]}, 16'h3, "event");
                clr(ch, 1'h1); // write of one must be ignored
                chk(ch_event_flag[ch], 16'h1, "flag one");
            end
            ch_cfg[ch] = '0;
        end
        $display("capture test done");
        w = 16 + $urandom_range(15);
        {counter_wrap_high, counter_wrap_low} = 16'(w);
        // value set before the restart, as at an overflow
        wr_val(1, 16'($urandom_range(w, 3)));
        for (int k = 0; k < 3; k++) begin
            ch_cfg[1] = tcc_ch_cfg_t'({2'h1, k == 0 ? TCC_ELS_SET :
                k == 1 ? TCC_ELS_CLR : TCC_ELS_TGL, 2'h0});
            restart();
            wait_n(w + 3);
            chk({ch_pin_oe[1], ch_pin_out[1]}, {15'h1, k != 1}, "cmp");
        end
        chk(ch_event_flag[1], 16'h1, "cmp flag");
        $display("compare test done");
        {counter_wrap_high, counter_wrap_low} = 16'h00ff;
        wr_val(0, 16'h0080);
        ch_cfg[0] = tcc_ch_cfg_t'(6'h1a); // high pulse: clear on compare
        restart();
        wait_n(300);
        high_count(256);
        chk(16'(h), 16'd128, "duty half");
        ch_cfg[0] = tcc_ch_cfg_t'(6'h19);
        wait_n(10);
        high_count(256);
        chk(16'(h), 16'h100, "duty full");
        $display("pwm test done");
        {counter_wrap_high, counter_wrap_low} = 16'h003f;
        link_mode_bit = 1'h1;
        ch_cfg[0] = tcc_ch_cfg_t'(6'h1a);
        wr_val(0, 16'h000a);
        restart();
        wait_n(70);
        chk(active_pair, 16'h0, "pair zero first");
        high_count(64);
        chk(16'(h), 16'h000a, "pair zero width");
        wr_val(1, 16'h0028); // only the idle pair is written
        wait_n(70);
        chk({ch_pin_oe[1], active_pair}, 16'h1, "pair one");
        high_count(64);
        chk(16'(h), 16'h0028, "pair one width");
        $display("linked test done");
        stop_test();
    end
endmodule : two_channel_capture_compare_timer_test
